// ---- common/sgcr_map.svh ----
// Offsets, field positions, reset values and timing figures of the switch
// global control bank. Included by the package, the aging timer and the top module.
`ifndef SGCR_MAP_SVH
`define SGCR_MAP_SVH

// Register indices; byte address is four times the index
`define SGCR_IDX_ID 4'h0
`define SGCR_IDX_CTRL1 4'h2
`define SGCR_IDX_BANK 4'he
`define SGCR_SW_BANK 6'h20
`define SGCR_RSV_BANK_LO 6'h14
`define SGCR_RSV_BANK_HI 6'h1f

`define SGCR_CTRL1_RST 16'h3400
`define SGCR_CTRL1_MASK 16'hbf09
`define SGCR_BANK_RST 6'h00

`define SGCR_B_START 0
`define SGCR_B_PASSALL 15
`define SGCR_B_TXFC 13
`define SGCR_B_RXFC 12
`define SGCR_B_LENCHK 11
`define SGCR_B_AGE 10
`define SGCR_B_FAST 9
`define SGCR_B_BACKOFF 8
`define SGCR_B_PASSFC 3
`define SGCR_B_LINKAGE 0

`define SGCR_LEN_LIMIT 16'h05dc

`define SGCR_CLK_HZ 64'h0000_0000_017d_7840
`define SGCR_FAST_AGE_US 64'h0000_0000_0000_0320
`define SGCR_NORMAL_AGE_S 64'h0000_0000_0000_012c
`define SGCR_FAST_AGE_CYC (`SGCR_FAST_AGE_US * `SGCR_CLK_HZ / 64'h0000_0000_000f_4240)
`define SGCR_NORMAL_AGE_CYC (`SGCR_NORMAL_AGE_S * `SGCR_CLK_HZ)

`endif

// ---- common/sgcr_pkg.sv ----
// Types shared by the switch global control bank.
// Assumes sgcr_map.svh is on the include path.
`include "sgcr_map.svh"

package sgcr_pkg;

  typedef enum logic [1:0] {SGCR_SEL_NONE, SGCR_SEL_ID, SGCR_SEL_CTRL1, SGCR_SEL_BANK} sgcr_sel_e;

  // The bank select word answers in every bank
  function automatic sgcr_sel_e sgcr_decode(input logic [5:0] bank, input logic [3:0] idx);
    sgcr_sel_e sel;
    sel = SGCR_SEL_NONE;
    if (idx == `SGCR_IDX_BANK)
      sel = SGCR_SEL_BANK;
    else if (bank == `SGCR_SW_BANK && idx == `SGCR_IDX_ID)
      sel = SGCR_SEL_ID;
    else if (bank == `SGCR_SW_BANK && idx == `SGCR_IDX_CTRL1)
      sel = SGCR_SEL_CTRL1;
    return sel;
  endfunction

endpackage

// ---- rtl/sgcr_sync2.sv ----
// Two-stage synchroniser for pin levels.
// Assumes inputs are quasi-static levels from another domain.
module sgcr_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ---- rtl/sgcr_age_timer.sv ----
// Address-table aging interval timer, normal or fast period.
// Assumes run, fast and restart come from logic on pclk.
`include "sgcr_map.svh"

module sgcr_age_timer #(
  parameter int CNT_W = 33,
  parameter longint unsigned FAST_CYC = `SGCR_FAST_AGE_CYC,
  parameter longint unsigned NORMAL_CYC = `SGCR_NORMAL_AGE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic fast,
  input wire logic restart,
  output logic tick
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;

  assign limit = fast ? CNT_W'(FAST_CYC - 1) : CNT_W'(NORMAL_CYC - 1);

  // Counter holds while stopped; >= so a switch to fast fires at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else if (restart)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else if (!run)
      tick <= 1'b0;
    else if (cnt >= limit)
    begin
      cnt <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule

// ---- rtl/sgcr_top.sv ----
// APB register bank for switch start, identity and global control one,
// plus the switch-side actions these controls steer.
// Assumes frame and pause inputs come from pclk logic; link pins are async.
//
// Notes on behaviour
// - Switch stays off after reset; start bit one starts, zero stops it.
// - Identity word reads family 15-8, chip 7-4, revision 3-1.
// - Bit 15 forwards bad frames, only while sniffer mode is on.
// - Bit 13 resets one; cleared means no pause frames are generated.
// - Bit 12 resets one; cleared means received pause frames are ignored.
// - Bit 11 drops frames with length field below 1500 mismatching payload.
// - Aging runs while bit 10 is one, its reset value; halts otherwise.
// - Bit 9 ages the table every 800us instead of normally.
// - Bit 8 selects aggressive back-off for half-duplex ports.
// - Bit 3 forwards pause frames instead of filtering them.
// - Bit 0: link loss triggers one fast pass, then normal 300s aging.
// - Any port unplugged ages out every learned address.
// - Banks 20 to 31 are empty; bank select answers in every bank.

`include "sgcr_map.svh"

module sgcr_top
  import sgcr_pkg::*;
#(
  parameter int PORTS = 2,
  parameter int ADDR_W = 8,
  parameter logic [7:0] FAMILY_CODE = 8'h5a,
  parameter logic [3:0] CHIP_CODE = 4'h3,
  parameter logic [2:0] REV_CODE = 3'h2,
  parameter longint unsigned FAST_AGE_CYC = `SGCR_FAST_AGE_CYC,
  parameter longint unsigned NORMAL_AGE_CYC = `SGCR_NORMAL_AGE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PORTS-1:0] link_up,
  input wire logic sniffer_mode,
  input wire logic frame_valid,
  input wire logic frame_bad,
  input wire logic frame_is_pause,
  input wire logic [15:0] len_field,
  input wire logic [15:0] payload_len,
  input wire logic pause_request,
  output logic switch_enable,
  output logic bad_frame_forward,
  output logic frame_drop,
  output logic pause_frame_forward,
  output logic pause_tx_generate,
  output logic rx_pause_throttle,
  output logic aggressive_backoff,
  output logic age_tick,
  output logic age_flush_all,
  output logic fast_pass_active
);

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [15:0] ctrl1;
  logic [5:0] bank;
  sgcr_sel_e sel;
  logic setup;
  logic access_done;
  logic addr_ok;

  assign setup = psel && !penable;
  assign access_done = psel && penable && pready;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:6] == '0);
  assign sel = addr_ok ? sgcr_decode(bank, paddr[5:2]) : SGCR_SEL_NONE;

  // Zero wait states: answer rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && (sel == SGCR_SEL_NONE);
      if (setup && !pwrite)
      begin
        unique case (sel)
          SGCR_SEL_ID:
            prdata <= {16'h0000, FAMILY_CODE, CHIP_CODE, REV_CODE, switch_enable};
          SGCR_SEL_CTRL1:
            prdata <= {16'h0000, ctrl1};
          SGCR_SEL_BANK:
            prdata <= {26'h0000000, bank};
          SGCR_SEL_NONE:
            prdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bank <= `SGCR_BANK_RST;
    else if (access_done && pwrite && sel == SGCR_SEL_BANK)
      bank <= pwdata[5:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      switch_enable <= 1'b0;
    else if (access_done && pwrite && sel == SGCR_SEL_ID)
      switch_enable <= pwdata[`SGCR_B_START];
  end

  // Reserved positions are masked on write so they always read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl1 <= `SGCR_CTRL1_RST;
    else if (access_done && pwrite && sel == SGCR_SEL_CTRL1)
      ctrl1 <= pwdata[15:0] & `SGCR_CTRL1_MASK;
  end

  // ----------------------------------------
  // Frame handling controls
  // ----------------------------------------
  logic len_mismatch;

  assign len_mismatch = (len_field < `SGCR_LEN_LIMIT) && (len_field != payload_len);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bad_frame_forward <= 1'b0;
      frame_drop <= 1'b0;
      pause_frame_forward <= 1'b0;
      pause_tx_generate <= 1'b0;
      rx_pause_throttle <= 1'b0;
      aggressive_backoff <= 1'b0;
    end
    else
    begin
      bad_frame_forward <= frame_valid && frame_bad && ctrl1[`SGCR_B_PASSALL]
        && sniffer_mode;
      frame_drop <= frame_valid && ctrl1[`SGCR_B_LENCHK] && len_mismatch;
      pause_frame_forward <= frame_valid && frame_is_pause
        && ctrl1[`SGCR_B_PASSFC];
      pause_tx_generate <= switch_enable && pause_request
        && ctrl1[`SGCR_B_TXFC];
      rx_pause_throttle <= frame_valid && frame_is_pause
        && ctrl1[`SGCR_B_RXFC];
      aggressive_backoff <= ctrl1[`SGCR_B_BACKOFF];
    end
  end

  // ----------------------------------------
  // Link watch and aging
  // ----------------------------------------
  logic [PORTS-1:0] link_sync;
  logic [PORTS-1:0] link_prev;
  logic link_lost;
  logic timer_tick;

  sgcr_sync2 #(
    .WIDTH(PORTS)
  ) u_link_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(link_up),
    .sync_out(link_sync)
  );

  assign link_lost = |(link_prev & ~link_sync);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      link_prev <= '0;
    else
      link_prev <= link_sync;
  end

  // Flush does not wait on the timer or the aging enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age_flush_all <= 1'b0;
    else
      age_flush_all <= link_lost;
  end

  // A new link loss in the tick cycle keeps the fast pass armed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fast_pass_active <= 1'b0;
    else if (link_lost && ctrl1[`SGCR_B_LINKAGE])
      fast_pass_active <= 1'b1;
    else if (timer_tick)
      fast_pass_active <= 1'b0;
  end

  sgcr_age_timer #(
    .CNT_W(33),
    .FAST_CYC(FAST_AGE_CYC),
    .NORMAL_CYC(NORMAL_AGE_CYC)
  ) u_age_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(ctrl1[`SGCR_B_AGE]),
    .fast(ctrl1[`SGCR_B_FAST] || fast_pass_active),
    .restart(link_lost && ctrl1[`SGCR_B_LINKAGE]),
    .tick(timer_tick)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age_tick <= 1'b0;
    else
      age_tick <= timer_tick && ctrl1[`SGCR_B_AGE];
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_write(sgcr_sel_e s);
    psel && penable && pready && pwrite && sel == s;
  endsequence

  sequence s_read_setup(sgcr_sel_e s);
    psel && !penable && !pwrite && sel == s;
  endsequence

  // Link loss while link-change aging is on
  sequence s_link_armed;
    link_lost && ctrl1[`SGCR_B_LINKAGE];
  endsequence

  sequence s_rsv_setup;
    psel && !penable && addr_ok && bank >= `SGCR_RSV_BANK_LO && bank <= `SGCR_RSV_BANK_HI
      && paddr[5:2] != `SGCR_IDX_BANK;
  endsequence

  chk_start_write: assert property (
    s_write(SGCR_SEL_ID) |=> switch_enable == $past(pwdata[`SGCR_B_START]))
    else $error("start bit not taken from write");
  chk_id_fields: assert property (
    s_read_setup(SGCR_SEL_ID) |=> pready && prdata[15:1] == {FAMILY_CODE, CHIP_CODE, REV_CODE})
    else $error("identity fields wrong");
  chk_bad_forward: assert property (
    bad_frame_forward |-> $past(frame_bad && ctrl1[`SGCR_B_PASSALL] && sniffer_mode))
    else $error("bad frame forwarded without pass-all and sniffer");
  chk_tx_pause_gate: assert property (
    !ctrl1[`SGCR_B_TXFC] ##1 !ctrl1[`SGCR_B_TXFC] |-> !pause_tx_generate)
    else $error("pause generated while disabled");
  chk_tx_pause_on: assert property (
    switch_enable && pause_request && ctrl1[`SGCR_B_TXFC] |=> pause_tx_generate)
    else $error("pause request not passed on");
  chk_rx_pause_gate: assert property (
    rx_pause_throttle |-> $past(ctrl1[`SGCR_B_RXFC] && frame_is_pause))
    else $error("throttle while rx pause disabled");
  chk_len_drop: assert property (
    frame_valid && ctrl1[`SGCR_B_LENCHK] && len_field < `SGCR_LEN_LIMIT
    && len_field != payload_len |=> frame_drop)
    else $error("length mismatch frame not dropped");
  chk_drop_cause: assert property (
    frame_drop |-> $past(frame_valid && ctrl1[`SGCR_B_LENCHK] && len_mismatch))
    else $error("frame dropped without length mismatch");
  chk_age_halt: assert property (
    !ctrl1[`SGCR_B_AGE] [*2] |-> !age_tick)
    else $error("aging tick while aging disabled");
  chk_backoff_level: assert property (
    aggressive_backoff == $past(ctrl1[`SGCR_B_BACKOFF]))
    else $error("back-off select does not follow control");
  chk_pass_forward: assert property (
    frame_valid && frame_is_pause |=> pause_frame_forward == $past(ctrl1[`SGCR_B_PASSFC]))
    else $error("pause frame forward wrong");
  chk_fast_arm: assert property (
    s_link_armed |=> fast_pass_active && age_flush_all)
    else $error("link loss did not arm fast pass");
  chk_fast_end: assert property (
    fast_pass_active && timer_tick && !(link_lost && ctrl1[`SGCR_B_LINKAGE])
    |=> !fast_pass_active)
    else $error("fast pass outlived its aging pass");
  chk_flush_all: assert property (
    link_lost |=> age_flush_all)
    else $error("unplug did not flush table");
  chk_rsv_bank: assert property (
    s_rsv_setup |=> pslverr && ($past(pwrite) || prdata == 32'h0000_0000))
    else $error("reserved bank answered");
  chk_bank_write: assert property (
    s_write(SGCR_SEL_BANK) |=> bank == $past(pwdata[5:0]))
    else $error("bank select not taken");
  chk_unmapped_write: assert property (
    s_write(SGCR_SEL_NONE) |=> $stable(ctrl1) && $stable(bank) && $stable(switch_enable))
    else $error("unmapped write changed a register");
  chk_rsv_bits: assert property (
    (ctrl1 & ~`SGCR_CTRL1_MASK) == 16'h0000)
    else $error("reserved control bit set");
  chk_ctrl_write: assert property (
    s_write(SGCR_SEL_CTRL1) |=> ctrl1 == ($past(pwdata[15:0]) & `SGCR_CTRL1_MASK))
    else $error("control write not masked");

endmodule

// ---- testbench/sgcr_apb_host.sv ----
// Host processor model: APB master for the switch control bank.
// Assumes a slave on the same pclk that raises pready after any wait.
module sgcr_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Request held until pready is sampled high; released data inverted
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

// ---- testbench/test_switch_global_control_regs.sv ----
// Self-checking bench for the switch global control bank.
// Assumes shortened aging counts: fast 8 cycles, normal 50 cycles.
module test_switch_global_control_regs;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] link_up = 2'b11;
  logic sniffer_mode = 1'b0;
  logic frame_valid = 1'b0;
  logic frame_bad = 1'b0;
  logic frame_is_pause = 1'b0;
  logic [15:0] len_field = 16'h0;
  logic [15:0] payload_len = 16'h0;
  logic pause_request = 1'b0;
  logic switch_enable, bad_frame_forward, frame_drop, pause_frame_forward;
  logic pause_tx_generate, rx_pause_throttle, aggressive_backoff;
  logic age_tick, age_flush_all, fast_pass_active;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int n;

  always #20 pclk = ~pclk;

  localparam int FAST_CYC = 32'h0000_0008;
  localparam int NORMAL_CYC = 32'h0000_0032;

  sgcr_top #(.FAMILY_CODE(8'h5a), .CHIP_CODE(4'h3), .REV_CODE(3'h2),
    .FAST_AGE_CYC(FAST_CYC), .NORMAL_AGE_CYC(NORMAL_CYC)) u_dut (.pclk(pclk),
    .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_up(link_up),
    .sniffer_mode(sniffer_mode), .frame_valid(frame_valid), .frame_bad(frame_bad),
    .frame_is_pause(frame_is_pause), .len_field(len_field), .payload_len(payload_len),
    .pause_request(pause_request), .switch_enable(switch_enable),
    .bad_frame_forward(bad_frame_forward), .frame_drop(frame_drop),
    .pause_frame_forward(pause_frame_forward), .pause_tx_generate(pause_tx_generate),
    .rx_pause_throttle(rx_pause_throttle), .aggressive_backoff(aggressive_backoff),
    .age_tick(age_tick), .age_flush_all(age_flush_all),
    .fast_pass_active(fast_pass_active));

  sgcr_apb_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    u_host.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic e;
    u_host.xfer(1'b0, a, 32'h0, r, e);
    chk(nm, r, x);
    chk("pslverr", {31'h0, e}, {31'h0, ex});
  endtask

  task automatic frm(input logic b, input logic [15:0] l);
    @(posedge pclk);
    frame_valid <= 1'b1;
    frame_bad <= b;
    frame_is_pause <= 1'b1;
    len_field <= l;
    payload_len <= 16'h0032;
    @(posedge pclk);
    frame_valid <= 1'b0;
    // Decision pulse still stands when this edge is sampled
    @(posedge pclk);
  endtask

  // Cycles between two ticks; 0 when no tick comes at all
  task automatic gap(output int g);
    int i;
    i = 0;
    g = 0;
    while (age_tick !== 1'b1 && i < 120)
    begin
      @(posedge pclk);
      #1;
      i++;
    end
    if (i < 120)
      do
      begin
        @(posedge pclk);
        #1;
        g++;
      end while (age_tick !== 1'b1 && g < 120);
  endtask

  task automatic drop_link(input logic [1:0] lvl, output int f, output logic fp);
    f = 0;
    fp = 1'b0;
    link_up <= lvl;
    repeat (10)
    begin
      @(posedge pclk);
      #1;
      if (age_flush_all === 1'b1)
      begin
        f++;
        fp = fast_pass_active;
      end
    end
    @(posedge pclk);
    link_up <= 2'b11;
    repeat (4) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd("bank", 8'h38, 32'h0, 1'b0);
    rd("ctrl_bank0", 8'h08, 32'h0, 1'b1);
    wr(8'h38, 32'h20);
    rd("ctrl_rst", 8'h08, 32'h3400, 1'b0);
    rd("id_rst", 8'h00, 32'h5a34, 1'b0);
    chk("switch_enable", switch_enable, 1'b0);
  endtask

  task automatic t_start;
    pause_request <= 1'b1;
    wr(8'h00, 32'hffff);
    rd("id_on", 8'h00, 32'h5a35, 1'b0);
    chk("switch_enable", switch_enable, 1'b1);
    chk("pause_tx", pause_tx_generate, 1'b1);
    wr(8'h08, 32'h1400);
    repeat (2) @(posedge pclk);
    chk("pause_tx_off", pause_tx_generate, 1'b0);
    wr(8'h00, 32'h0);
    repeat (2) @(posedge pclk);
    chk("switch_off", switch_enable, 1'b0);
  endtask

  task automatic t_frames;
    logic [3:0] o;
    wr(8'h08, 32'hffff);
    rd("ctrl_rsv", 8'h08, 32'hbf09, 1'b0);
    chk("backoff", aggressive_backoff, 1'b1);
    sniffer_mode <= 1'b1;
    frm(1'b1, 16'h0064);
    o = {bad_frame_forward, frame_drop, pause_frame_forward, rx_pause_throttle};
    chk("frame_all_on", o, 4'hf);
    sniffer_mode <= 1'b0;
    frm(1'b1, 16'h05dc);
    chk("frame_1500", {bad_frame_forward, frame_drop}, 2'b00);
    wr(8'h08, 32'h0);
    frm(1'b1, 16'h0064);
    o = {bad_frame_forward, frame_drop, pause_frame_forward, rx_pause_throttle};
    chk("frame_all_off", o, 4'h0);
    chk("backoff_off", aggressive_backoff, 1'b0);
  endtask

  task automatic t_age;
    wr(8'h08, 32'h0400);
    gap(n);
    chk("normal_period", n, NORMAL_CYC);
    wr(8'h08, 32'h0600);
    gap(n);
    gap(n);
    chk("fast_period", n, FAST_CYC);
    wr(8'h08, 32'h0);
    gap(n);
    chk("age_off", n, 32'h0);
  endtask

  task automatic t_link;
    int f;
    logic fp;
    wr(8'h08, 32'h0401);
    drop_link(2'b10, f, fp);
    chk("flush", f, 32'h1);
    chk("fast_pass", fp, 1'b1);
    repeat (20) @(posedge pclk);
    chk("fast_pass_end", fast_pass_active, 1'b0);
    wr(8'h08, 32'h0400);
    drop_link(2'b01, f, fp);
    chk("flush_plain", f, 32'h1);
    chk("no_fast_pass", fp, 1'b0);
  endtask

  task automatic t_rsv_bank;
    wr(8'h38, 32'h14);
    rd("id_rsv", 8'h00, 32'h0, 1'b1);
    rd("bank_rsv", 8'h38, 32'h14, 1'b0);
    wr(8'h38, 32'h1f);
    rd("ctrl_rsv_bank", 8'h08, 32'h0, 1'b1);
    wr(8'h08, 32'hffff);
    wr(8'h38, 32'h20);
    rd("ctrl_kept", 8'h08, 32'h0400, 1'b0);
  endtask

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_start();
    t_frames();
    t_age();
    t_link();
    t_rsv_bank();
    wrap_up();
  end
endmodule
